// ### pvs_pkg.sv
// Shared constants for the vendor status and fast-path control bank
package pvs_pkg;
    // Printed register numbers kept as indices; byte address is index * 4
    localparam logic [7:0] IDX_STATUS = 8'h1c;
    localparam logic [7:0] IDX_CONTROL = 8'h1d;
    localparam logic [31:0] ADDR_STATUS = {22'h000000, IDX_STATUS, 2'b00};
    localparam logic [31:0] ADDR_CONTROL = {22'h000000, IDX_CONTROL, 2'b00};

    // Event status field positions
    localparam int ST_MISSING_SFD = 8;
    localparam int ST_CODE_VIOL = 7;
    localparam int ST_POLARITY = 6;
    localparam int ST_DISCONNECT = 5;
    localparam int ST_UNLOCKED = 4;
    localparam int ST_FALSE_CARRIER = 3;
    localparam int ST_FORCED_JAM = 2;
    localparam int ST_FAST_UP = 1;
    localparam int ST_SLOW_UP = 0;
    localparam logic [15:0] ST_LATCH_MASK = 16'h01bc;
    localparam logic [15:0] ST_UNUSED_MASK = 16'hfe00;

    // Fast-path control field positions
    localparam int CT_SOFT_RESET = 15;
    localparam int CT_FACTORY_A = 14;
    localparam int CT_FACTORY_B = 13;
    localparam int CT_FAST_TX_ON = 12;
    localparam int CT_CRS_RX_ONLY = 10;
    localparam int CT_LINK_ERR_EN = 9;
    localparam int CT_PACKET_ERROR_CODE_ENABLE_EN = 8;
    localparam int CT_CODEC_BYP = 6;
    localparam int CT_ALIGNER_BYP = 5;
    localparam int CT_SCRAMBLER_BYP = 4;
    localparam int CT_CI_EN = 3;
    localparam int CT_JAM_COL = 2;
    localparam logic [15:0] CT_RESET = 16'h1000;
    localparam logic [15:0] CT_STRAP_MASK = 16'h0050;
    localparam logic [15:0] CT_STORE_MASK = 16'h7fff;

    // Receive-data error codes, plain defaults
    localparam logic [3:0] RXD_LINK_ERR = 4'h1;
    localparam logic [3:0] RXD_UNLOCKED = 4'h2;
    localparam logic [3:0] RXD_CODE_VIOL = 4'h3;

    // Cycles after reset release before the synchronised strap is valid
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    // AHB encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int HTRANS_ACTIVE_BIT = 1;
endpackage

// ### pvs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pvs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Data
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// ### pvs_ahb_slave.sv
// AHB-Lite slave front end with one wait state per word transfer
`timescale 1ns/1ps
module pvs_ahb_slave (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // AHB-Lite
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Register side
    output logic o_wr_stb,
    output logic o_rd_stb,
    output logic [31:0] o_addr,
    output logic [31:0] o_wdata,
    input wire logic [15:0] i_rdata
);
    typedef enum logic [2:0] {
        PVS_IDLE = 3'b001,
        PVS_ACCESS = 3'b010,
        PVS_DONE = 3'b100
    } pvs_bus_state_t;

    pvs_bus_state_t state_r;
    logic write_r;
    logic take;

    // Non-word sizes are ignored but still answered OKAY
    assign take = i_hsel && i_htrans[pvs_pkg::HTRANS_ACTIVE_BIT] &&
                  i_hready && (i_hsize == pvs_pkg::HSIZE_WORD);

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= PVS_IDLE;
        end else begin
            unique case (state_r)
                PVS_IDLE: begin
                    if (take) begin
                        state_r <= PVS_ACCESS;
                    end
                end
                PVS_ACCESS: begin
                    state_r <= PVS_DONE;
                end
                PVS_DONE: begin
                    state_r <= take ? PVS_ACCESS : PVS_IDLE;
                end
                default: begin
                    state_r <= PVS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_addr <= 32'h00000000;
            write_r <= 1'b0;
        end else if (take) begin
            o_addr <= i_haddr;
            write_r <= i_hwrite;
        end
    end

    // Read data is registered so the clear-on-read lands on the same edge
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_hrdata <= 32'h00000000;
        end else if (o_rd_stb) begin
            o_hrdata <= {16'h0000, i_rdata};
        end
    end

    assign o_hreadyout = (state_r != PVS_ACCESS);
    assign o_hresp = 1'b0;
    assign o_wr_stb = (state_r == PVS_ACCESS) && write_r;
    assign o_rd_stb = (state_r == PVS_ACCESS) && !write_r;
    assign o_wdata = i_hwdata;
endmodule

// ### pvs_regs.sv
// Vendor event status and fast-path control registers with MII effects
`timescale 1ns/1ps
module pvs_regs (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // AHB-Lite
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Strap pin
    input wire logic i_pcs_strap_pin,
    // Transceiver events and levels
    input wire logic i_fast_mode,
    input wire logic i_missing_sfd,
    input wire logic i_code_violation,
    input wire logic i_polarity_reversed,
    input wire logic i_polarity_autofix_enable,
    input wire logic i_disconnect,
    input wire logic i_scrambler_unlocked,
    input wire logic i_false_carrier,
    input wire logic i_forced_jam,
    input wire logic i_fast_link_up,
    input wire logic i_slow_link_up,
    // MII and line side inputs
    input wire logic [3:0] i_rx_data,
    input wire logic i_rx_er,
    input wire logic i_rx_active,
    input wire logic i_tx_active,
    input wire logic i_col_raw,
    input wire logic i_ci_jam,
    input wire logic i_fast_tx_p,
    input wire logic i_fast_tx_n,
    // MII and line side outputs
    output logic [3:0] o_rxd,
    output logic o_rx_er,
    output logic o_crs,
    output logic o_col,
    output logic o_fast_tx_p,
    output logic o_fast_tx_n,
    // Controls to the datapath
    output logic o_polarity_correct,
    output logic o_codec_bypass,
    output logic o_aligner_bypass,
    output logic o_scrambler_bypass,
    output logic o_carrier_integrity_enable,
    output logic o_factory_reset_a,
    output logic o_factory_reset_b,
    output logic o_mgmt_soft_reset
);
    logic wr_stb, rd_stb, wr_ctrl, rd_status, soft_req;
    logic strap_sync, strap_done_r, pol_status;
    logic [31:0] addr, wdata;
    logic [15:0] rdata, latched_r, events, status_val;
    logic [15:0] ctrl_r, strap_bits_r;
    logic [1:0] strap_cnt_r;

    pvs_ahb_slave u_bus (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hsize(i_hsize),
        .i_hwdata(i_hwdata),
        .i_hready(i_hready),
        .o_hrdata(o_hrdata),
        .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp),
        .o_wr_stb(wr_stb),
        .o_rd_stb(rd_stb),
        .o_addr(addr),
        .o_wdata(wdata),
        .i_rdata(rdata)
    );

    pvs_sync #(
        .WIDTH(1)
    ) u_strap_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_async(i_pcs_strap_pin),
        .o_sync(strap_sync)
    );

    // Writes to the status word are dropped, so no status write decode
    assign wr_ctrl = wr_stb && (addr == pvs_pkg::ADDR_CONTROL);
    assign rd_status = rd_stb && (addr == pvs_pkg::ADDR_STATUS);
    assign soft_req = wr_ctrl && wdata[pvs_pkg::CT_SOFT_RESET];
    // Event vector gated by the mode in which each flag is meaningful
    always_comb begin
        events = 16'h0000;
        events[pvs_pkg::ST_MISSING_SFD] = i_missing_sfd && !i_fast_mode;
        events[pvs_pkg::ST_CODE_VIOL] = i_code_violation && !i_fast_mode;
        events[pvs_pkg::ST_DISCONNECT] = i_disconnect && i_fast_mode;
        events[pvs_pkg::ST_UNLOCKED] = i_scrambler_unlocked && i_fast_mode;
        events[pvs_pkg::ST_FALSE_CARRIER] = i_false_carrier && i_fast_mode;
        events[pvs_pkg::ST_FORCED_JAM] = i_forced_jam && i_fast_mode;
    end

    // Latched flags: clear on read or soft reset, a same-cycle event wins
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            latched_r <= 16'h0000;
        end else if (soft_req) begin
            latched_r <= events;
        end else if (rd_status) begin
            latched_r <= events;
        end else begin
            latched_r <= latched_r | events;
        end
    end

    assign pol_status = i_polarity_autofix_enable && i_polarity_reversed &&
                        !i_fast_mode;

    always_comb begin
        status_val = latched_r & pvs_pkg::ST_LATCH_MASK;
        status_val[pvs_pkg::ST_POLARITY] = pol_status;
        status_val[pvs_pkg::ST_FAST_UP] = i_fast_link_up;
        status_val[pvs_pkg::ST_SLOW_UP] = i_slow_link_up;
        status_val = status_val & ~pvs_pkg::ST_UNUSED_MASK;
    end

    // Soft reset bit is never stored, so it always reads back zero
    always_comb begin
        if (addr == pvs_pkg::ADDR_STATUS) begin
            rdata = status_val;
        end else if (addr == pvs_pkg::ADDR_CONTROL) begin
            rdata = ctrl_r;
        end else begin
            rdata = 16'h0000;
        end
    end

    // Strap is caught a fixed number of cycles after reset release
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
            strap_bits_r <= 16'h0000;
        end else if (!strap_done_r) begin
            if (strap_cnt_r == pvs_pkg::STRAP_WAIT) begin
                strap_done_r <= 1'b1;
                strap_bits_r <= strap_sync ? 16'h0000 :
                                pvs_pkg::CT_STRAP_MASK;
            end else begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
        end
    end

    // Reserved bits are stored as written; the controller keeps them zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_r <= pvs_pkg::CT_RESET;
        end else if (soft_req) begin
            ctrl_r <= pvs_pkg::CT_RESET | strap_bits_r;
        end else if (wr_ctrl) begin
            ctrl_r <= wdata[15:0] & pvs_pkg::CT_STORE_MASK;
        end else if (!strap_done_r &&
                     (strap_cnt_r == pvs_pkg::STRAP_WAIT) && !strap_sync) begin
            ctrl_r <= ctrl_r | pvs_pkg::CT_STRAP_MASK;
        end
    end

    // Pulse tells the standard register block to return to defaults
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_mgmt_soft_reset <= 1'b0;
        end else begin
            o_mgmt_soft_reset <= soft_req;
        end
    end
    assign o_codec_bypass = ctrl_r[pvs_pkg::CT_CODEC_BYP];
    assign o_aligner_bypass = ctrl_r[pvs_pkg::CT_ALIGNER_BYP];
    assign o_scrambler_bypass = ctrl_r[pvs_pkg::CT_SCRAMBLER_BYP];
    assign o_carrier_integrity_enable = ctrl_r[pvs_pkg::CT_CI_EN];
    assign o_factory_reset_a = ctrl_r[pvs_pkg::CT_FACTORY_A];
    assign o_factory_reset_b = ctrl_r[pvs_pkg::CT_FACTORY_B];

    // Receive data with error-code substitution; link error has priority
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rxd <= 4'h0;
            o_rx_er <= 1'b0;
        end else begin
            o_rx_er <= i_rx_er;
            if (i_rx_er && ctrl_r[pvs_pkg::CT_LINK_ERR_EN]) begin
                o_rxd <= pvs_pkg::RXD_LINK_ERR;
            end else if (i_rx_er && ctrl_r[pvs_pkg::CT_PACKET_ERROR_CODE_ENABLE_EN] &&
                         i_scrambler_unlocked) begin
                o_rxd <= pvs_pkg::RXD_UNLOCKED;
            end else if (i_code_violation && !i_fast_mode) begin
                o_rxd <= pvs_pkg::RXD_CODE_VIOL;
            end else begin
                o_rxd <= i_rx_data;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_crs <= 1'b0;
        end else begin
            o_crs <= i_rx_active ||
                     (!ctrl_r[pvs_pkg::CT_CRS_RX_ONLY] && i_tx_active);
        end
    end

    // Jam only counts when carrier integrity itself is running
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_col <= 1'b0;
        end else begin
            o_col <= i_col_raw || (ctrl_r[pvs_pkg::CT_JAM_COL] &&
                     ctrl_r[pvs_pkg::CT_CI_EN] && i_ci_jam);
        end
    end

    // Transmitter off parks the pair at fixed levels, low and high
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_fast_tx_p <= 1'b0;
            o_fast_tx_n <= 1'b1;
        end else if (ctrl_r[pvs_pkg::CT_FAST_TX_ON]) begin
            o_fast_tx_p <= i_fast_tx_p;
            o_fast_tx_n <= i_fast_tx_n;
        end else begin
            o_fast_tx_p <= 1'b0;
            o_fast_tx_n <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_polarity_correct <= 1'b0;
        end else begin
            o_polarity_correct <= pol_status;
        end
    end
    // Checks
    sequence seq_soft_write;
        wr_stb && (addr == pvs_pkg::ADDR_CONTROL) &&
        wdata[pvs_pkg::CT_SOFT_RESET];
    endsequence
    sequence seq_defaults;
        (ctrl_r == (pvs_pkg::CT_RESET | strap_bits_r)) && o_mgmt_soft_reset
        ##1 !o_mgmt_soft_reset;
    endsequence
    sequence seq_status_read;
        rd_stb && (addr == pvs_pkg::ADDR_STATUS);
    endsequence
    chk_missing_sfd_set: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_missing_sfd && !i_fast_mode) |=>
        latched_r[pvs_pkg::ST_MISSING_SFD])
        else $error("missing delimiter flag not set");
    chk_flags_sticky: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (latched_r[pvs_pkg::ST_CODE_VIOL] && !rd_status && !soft_req) |=>
        latched_r[pvs_pkg::ST_CODE_VIOL])
        else $error("code violation flag dropped without read");
    chk_code_rxd: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_code_violation && !i_fast_mode && !i_rx_er) |=>
        (o_rxd == pvs_pkg::RXD_CODE_VIOL) &&
        latched_r[pvs_pkg::ST_CODE_VIOL])
        else $error("code violation not reported");
    chk_polarity_report: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        status_val[pvs_pkg::ST_POLARITY] |=> o_polarity_correct)
        else $error("polarity correction not applied");
    chk_disconnect_latch: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_disconnect && i_fast_mode) ##1 (!rd_status && !soft_req) |=>
        latched_r[pvs_pkg::ST_DISCONNECT])
        else $error("disconnect flag not held");
    chk_unlock_jam: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_fast_mode && i_scrambler_unlocked && i_forced_jam) |=>
        latched_r[pvs_pkg::ST_UNLOCKED] && latched_r[pvs_pkg::ST_FORCED_JAM])
        else $error("unlock or jam flag not latched");
    chk_slow_mode_gate: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (!i_fast_mode && !latched_r[pvs_pkg::ST_FALSE_CARRIER]) |=>
        !latched_r[pvs_pkg::ST_FALSE_CARRIER] || $past(i_fast_mode))
        else $error("false carrier latched outside fast mode");
    chk_link_live: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        seq_status_read |=>
        (o_hrdata[pvs_pkg::ST_FAST_UP] == $past(i_fast_link_up)) &&
        (o_hrdata[pvs_pkg::ST_SLOW_UP] == $past(i_slow_link_up)))
        else $error("link up bits not live");
    chk_unused_zero: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        seq_status_read |=> (o_hrdata[15:9] == 7'h00))
        else $error("unused status bits not zero");
    chk_soft_reset: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        seq_soft_write |=> seq_defaults)
        else $error("soft reset did not restore defaults");
    chk_tx_off: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !ctrl_r[pvs_pkg::CT_FAST_TX_ON] |=> !o_fast_tx_p && o_fast_tx_n)
        else $error("transmitter not forced off");
    chk_crs_select: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_tx_active && !i_rx_active) |=>
        (o_crs == !$past(ctrl_r[pvs_pkg::CT_CRS_RX_ONLY])))
        else $error("carrier sense select wrong");
    chk_link_err_code: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_rx_er && ctrl_r[pvs_pkg::CT_LINK_ERR_EN]) |=>
        o_rx_er && (o_rxd == pvs_pkg::RXD_LINK_ERR))
        else $error("link error code missing");
    chk_packet_error_code_enable_code: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_rx_er && !ctrl_r[pvs_pkg::CT_LINK_ERR_EN] &&
         ctrl_r[pvs_pkg::CT_PACKET_ERROR_CODE_ENABLE_EN] && i_scrambler_unlocked) |=>
        (o_rxd == pvs_pkg::RXD_UNLOCKED))
        else $error("packet error code missing");
    chk_strap_preset: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        $rose(strap_done_r) && !$past(strap_sync) && !$past(wr_ctrl) |->
        o_codec_bypass && o_scrambler_bypass)
        else $error("strap did not preset bypass bits");
    chk_jam_col: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ci_jam && o_carrier_integrity_enable &&
         ctrl_r[pvs_pkg::CT_JAM_COL]) |=> o_col)
        else $error("integrity jam not ORed into collision");
    chk_read_clear: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        seq_status_read |=>
        (o_hrdata[15:0] == ($past(status_val))) &&
        ((latched_r & pvs_pkg::ST_LATCH_MASK) ==
         ($past(events) & pvs_pkg::ST_LATCH_MASK)))
        else $error("read did not return then clear flags");
endmodule

// ### pvs_mac_model.sv
// Bus-master model of the station management controller
`timescale 1ns/1ps
module pvs_mac_model (
    // Clock and slave answer
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    // Bus request
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    logic rdy_q;
    logic [31:0] rd_q;

    // Settled mid-cycle copies avoid racing the slave's own edge updates
    always @(negedge i_clk) begin
        rdy_q = i_hready;
        rd_q = i_hrdata;
    end

    initial begin
        o_hsel <= 1'b0;
        o_haddr <= 32'h0;
        o_htrans <= 2'h0;
        o_hwrite <= 1'b0;
        o_hsize <= 3'h2;
        o_hwdata <= 32'h0;
    end

    // Caller enters right after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        o_hsel <= 1'b1;
        o_htrans <= 2'h2;
        o_haddr <= a;
        o_hwrite <= w;
        o_hsize <= 3'h2;
        do @(posedge i_clk); while (rdy_q !== 1'b1);
        o_hsel <= 1'b0;
        o_htrans <= 2'h0;
        o_haddr <= ~a;
        o_hwdata <= d & ~32'h0883;
        do @(posedge i_clk); while (rdy_q !== 1'b1);
        r = rd_q;
        // Released data no longer shows the written word
        o_hwdata <= ~d;
    endtask
endmodule

// ### phy_vendor_status_control_regs_tb.sv
// Self-checking bench for the vendor status and control bank
`timescale 1ns/1ps
module phy_vendor_status_control_regs_tb;
    logic i_clk = 1'b0;
    logic i_rstn, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
    logic [31:0] i_haddr, i_hwdata, o_hrdata;
    logic [1:0] i_htrans;
    logic [2:0] i_hsize;
    logic i_pcs_strap_pin, i_fast_mode, i_missing_sfd, i_code_violation;
    logic i_polarity_reversed, i_polarity_autofix_enable, i_disconnect;
    logic i_scrambler_unlocked, i_false_carrier, i_forced_jam;
    logic i_fast_link_up, i_slow_link_up, i_rx_er, i_rx_active, i_tx_active;
    logic i_col_raw, i_ci_jam, i_fast_tx_p, i_fast_tx_n;
    logic [3:0] i_rx_data, o_rxd;
    logic o_rx_er, o_crs, o_col, o_fast_tx_p, o_fast_tx_n;
    logic o_polarity_correct, o_codec_bypass, o_aligner_bypass;
    logic o_scrambler_bypass, o_carrier_integrity_enable;
    logic o_factory_reset_a, o_factory_reset_b, o_mgmt_soft_reset;
    int n_fail = 0;
    int tests_run = 0;
    int n_soft = 0;

    always #20 i_clk = ~i_clk;
    assign i_hready = o_hreadyout;

    // Counts soft reset pulses; one write must give exactly one
    always @(posedge i_clk) begin
        if (o_mgmt_soft_reset === 1'b1) begin
            n_soft <= n_soft + 1;
        end
    end

    pvs_mac_model u_mac (.i_clk, .i_hready(o_hreadyout), .i_hrdata(o_hrdata),
        .o_hsel(i_hsel), .o_haddr(i_haddr), .o_htrans(i_htrans),
        .o_hwrite(i_hwrite), .o_hsize(i_hsize), .o_hwdata(i_hwdata));
    pvs_regs u_dut (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        u_mac.xfer(1'b1, a, d, r);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        u_mac.xfer(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask

    task automatic wrap_up;
        $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Waits past the strap capture before any bus traffic
    task automatic do_reset(input logic strap);
        i_pcs_strap_pin <= strap;
        i_rstn <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask

    task automatic t_slow;
        {i_slow_link_up, i_polarity_autofix_enable} <= 2'h3;
        {i_polarity_reversed, i_missing_sfd, i_code_violation} <= 3'h7;
        i_disconnect <= 1'b1;
        @(posedge i_clk);
        {i_missing_sfd, i_code_violation, i_disconnect} <= 3'h0;
        @(negedge i_clk);
        chk({28'h0, o_rxd}, 32'h3);
        chk({31'h0, o_polarity_correct}, 32'h1);
        @(posedge i_clk);
        rdc(pvs_pkg::ADDR_STATUS, 32'h1c1);
        rdc(pvs_pkg::ADDR_STATUS, 32'h41);
    endtask

    task automatic t_fast;
        {i_fast_mode, i_slow_link_up, i_fast_link_up} <= 3'h5;
        {i_disconnect, i_scrambler_unlocked, i_false_carrier} <= 3'h7;
        {i_forced_jam, i_missing_sfd} <= 2'h3;
        @(posedge i_clk);
        {i_disconnect, i_scrambler_unlocked, i_false_carrier} <= 3'h0;
        {i_forced_jam, i_missing_sfd} <= 2'h0;
        @(posedge i_clk);
        rdc(pvs_pkg::ADDR_STATUS, 32'h3e);
        rdc(pvs_pkg::ADDR_STATUS, 32'h02);
    endtask

    task automatic t_ctrl;
        rdc(pvs_pkg::ADDR_CONTROL, 32'h1000);
        wr(pvs_pkg::ADDR_CONTROL, 32'h7f7f);
        rdc(pvs_pkg::ADDR_CONTROL, 32'h777c);
        {i_tx_active, i_ci_jam, i_rx_er, i_fast_tx_p, i_fast_tx_n} <= 5'h1e;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk({o_rx_er, o_factory_reset_a, o_factory_reset_b, o_crs, o_col,
             o_rxd, o_codec_bypass, o_aligner_bypass, o_scrambler_bypass,
             o_carrier_integrity_enable,
             o_fast_tx_p}, 32'h3a3f);
        @(posedge i_clk);
        wr(pvs_pkg::ADDR_CONTROL, 32'h0100);
        i_scrambler_unlocked <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk({o_hresp, o_crs, o_col, o_rxd, o_fast_tx_p, o_fast_tx_n},
            32'h89);
        @(posedge i_clk);
        i_scrambler_unlocked <= 1'b0;
        wr(pvs_pkg::ADDR_CONTROL, 32'h8000);
        rdc(pvs_pkg::ADDR_CONTROL, 32'h1000);
        rdc(pvs_pkg::ADDR_STATUS, 32'h02);
        chk(n_soft, 32'h1);
    endtask

    initial begin
        {i_fast_mode, i_missing_sfd, i_code_violation,
         i_polarity_reversed, i_polarity_autofix_enable, i_disconnect,
         i_scrambler_unlocked, i_false_carrier, i_forced_jam, i_fast_link_up,
         i_slow_link_up, i_rx_data, i_rx_er, i_rx_active, i_tx_active,
         i_col_raw, i_ci_jam, i_fast_tx_p, i_fast_tx_n} <= '0;
        do_reset(1'b1);
        rdc(pvs_pkg::ADDR_STATUS, 32'h0);
        t_slow;
        t_fast;
        t_ctrl;
        do_reset(1'b0);
        rdc(pvs_pkg::ADDR_CONTROL, 32'h1050);
        wrap_up;
    end

    // The sequence needs under a hundred cycles; this is far beyond it
    initial begin
        #100000;
        n_fail++;
        wrap_up;
    end
endmodule
